// >>> hw/ssd_pkg.sv
// Purpose: shared constants and carriers for the serial status/data block
// Assumes: byte-wide register port, 10 MHz system clock
// Notes:   all offsets and the control, status and pin reset values live here
package ssd_pkg;

    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] ADDR_DATA = 8'h31;
    localparam logic [7:0] ADDR_CTRL = 8'h32;
    localparam logic [7:0] ADDR_STAT = 8'h33;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] STAT_WR_MASK = 8'h07;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ***************************************************
    // serial timing
    // ***************************************************
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [3:0] PIN_IDLE = 4'h1;
    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV8 = 7'h04;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV32 = 7'h10;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;

    // ***************************************************
    // carriers
    // ***************************************************
    typedef struct packed {
        logic irq_enable;
        logic peripheral_enable;
        logic divider_enable;
        logic master_select;
        logic clk_idle_high;
        logic clk_phase_late;
        logic [1:0] rate_sel;
    } ssd_ctrl_t;

    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic overrun_flag;
        logic mode_fault_flag;
        logic rsvd;
        logic output_disable;
        logic select_source_software;
        logic select_internal_level;
    } ssd_csr_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } ssd_pins_in_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic ss_gpio_free;
    } ssd_pins_out_t;

    // half period of the master serial clock in system cycles
    function automatic logic [6:0] ssd_half_period(input logic [2:0] sel);
        logic [6:0] h;
        h = HALF_DIV8;
        unique case (sel)
            3'h4: h = HALF_DIV4;
            3'h0: h = HALF_DIV8;
            3'h1: h = HALF_DIV16;
            3'h6: h = HALF_DIV32;
            3'h2: h = HALF_DIV64;
            3'h3: h = HALF_DIV128;
            default: h = HALF_DIV8;
        endcase
        return h;
    endfunction

endpackage

// >>> hw/ssd_sync.sv
// Purpose: two-stage synchroniser for the serial pins
// Assumes: inputs are asynchronous to clk_sys
// Notes:   only the second stage is visible outside
`timescale 1ns/100ps
module ssd_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ssd_sync_st_t;

    ssd_sync_st_t s_reg;
    ssd_sync_st_t s_next;

    always_comb
    begin
        s_next.meta = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            s_reg <= {RST_VAL, RST_VAL};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;

endmodule

// >>> hw/ssd_top.sv
// Purpose: serial peripheral status, flags and data port
// Assumes: 10 MHz clk_sys, pins sampled through ssd_sync
// Notes:   one byte shifter, receive buffer, no transmit buffer
`timescale 1ns/100ps

// Contract
// R1 - done flag bit 7 set on byte end
// R2 - done cleared by status then data access
// R3 - one interrupt from done, overrun, fault
// R4 - data writes ignored until status read
// R5 - collision flag bit 6 on busy write
// R6 - overrun bit 5 when done still set
// R7 - overrun cleared by status read
// R8 - fault bit 4 on select low as master
// R9 - fault cleared by status then control write
// R10 - output disable bit 2 releases data out
// R11 - software select ignores the select pin
// R12 - internal level bit 0 selects when low
// R13 - master data write starts next byte
// R14 - received byte copied to buffer at end
// R15 - data read returns buffer, not shifter
// R16 - data write loads shifter directly
// R17 - software writes zero to status bit 3
// R18 - status register resets to zero
// R19 - fault clears enable and master bits
// R20 - interrupt enable low suppresses interrupt
// R21 - collision cleared by status then data read
module ssd_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // serial pins
    input wire ssd_pkg::ssd_pins_in_t pin_in,
    output ssd_pkg::ssd_pins_out_t pin_out,
    // interrupt
    output logic irq_out
);

    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        ssd_pkg::ssd_ctrl_t ctrl;
        ssd_pkg::ssd_csr_t csr;
        logic [7:0] rx_buf;
        logic [7:0] shifter;
        logic rx_bit;
        logic [3:0] edge_cnt;
        logic busy;
        logic sck_lvl;
        logic [6:0] div_cnt;
        logic sck_prev;
        logic stat_seen;
        logic mode_fault_flag_seen;
        logic [7:0] rd_data;
        ssd_pkg::ssd_pins_out_t pins;
        logic irq;
    } ssd_state_t;

    localparam ssd_state_t ST_RESET = '{
        ctrl: ssd_pkg::CTRL_RESET,
        csr: ssd_pkg::STAT_RESET,
        default: '0
    };

    ssd_state_t s_reg;
    ssd_state_t s_next;
    logic [1:0] rst_pipe_reg;
    logic rst_sync_b;
    ssd_pkg::ssd_pins_in_t pin_sync;

    logic stat_rd;
    logic stat_wr;
    logic ctrl_wr;
    logic data_rd;
    logic data_wr;
    logic wr_blocked;
    logic ss_int;
    logic sel_slave;
    logic in_bit;
    logic edge_go;
    logic smp;
    logic shf;
    logic byte_done;
    logic [7:0] new_byte;
    logic [6:0] half;

    // ***************************************************
    // reset release and pin sampling
    // ***************************************************
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_pipe_reg <= 2'h0;
        end
        else
        begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    assign rst_sync_b = rst_pipe_reg[1];

    ssd_sync #(
        .W(4),
        .RST_VAL(ssd_pkg::PIN_IDLE)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_sync_b(rst_sync_b),
        .d(pin_in),
        .q(pin_sync)
    );

    // ***************************************************
    // next state
    // ***************************************************
    always_comb
    begin
        s_next = s_reg;
        stat_rd = reg_rd && (reg_addr == ssd_pkg::ADDR_STAT);
        stat_wr = reg_wr && (reg_addr == ssd_pkg::ADDR_STAT);
        ctrl_wr = reg_wr && (reg_addr == ssd_pkg::ADDR_CTRL);
        data_rd = reg_rd && (reg_addr == ssd_pkg::ADDR_DATA);
        data_wr = reg_wr && (reg_addr == ssd_pkg::ADDR_DATA);
        half = ssd_pkg::ssd_half_period({s_reg.ctrl.divider_enable,
                                         s_reg.ctrl.rate_sel});
        // R11 ignore pin
        // R12 internal level
        ss_int = s_reg.csr.select_source_software ?
                 s_reg.csr.select_internal_level : pin_sync.ss_n;
        sel_slave = s_reg.ctrl.peripheral_enable &&
                    !s_reg.ctrl.master_select && !ss_int;
        in_bit = s_reg.ctrl.master_select ? pin_sync.miso : pin_sync.mosi;
        // R4 writes held off
        wr_blocked = s_reg.csr.transfer_done_flag && !s_reg.stat_seen;
        edge_go = 1'b0;
        smp = 1'b0;
        shf = 1'b0;
        byte_done = 1'b0;
        new_byte = s_reg.shifter;

        // read data stand one cycle only
        s_next.rd_data = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                // R15 buffer read
                ssd_pkg::ADDR_DATA: s_next.rd_data = s_reg.rx_buf;
                ssd_pkg::ADDR_CTRL: s_next.rd_data = s_reg.ctrl;
                ssd_pkg::ADDR_STAT: s_next.rd_data = {s_reg.csr[7:4], 1'b0,
                                                      s_reg.csr[2:0]};
                default: s_next.rd_data = ssd_pkg::RD_UNMAPPED;
            endcase
        end

        // ***************************************************
        // software sequences (clears first, sets later)
        // ***************************************************
        if (stat_rd)
        begin
            s_next.stat_seen = 1'b1;
            // R7 overrun clear
            s_next.csr.overrun_flag = 1'b0;
        end
        if ((stat_rd || stat_wr) && s_reg.csr.mode_fault_flag)
        begin
            s_next.mode_fault_flag_seen = 1'b1;
        end
        if (stat_wr)
        begin
            // R17 bit 3 kept zero whatever is written
            s_next.csr[2:0] = reg_wdata[2:0] & ssd_pkg::STAT_WR_MASK[2:0];
        end
        if (ctrl_wr)
        begin
            s_next.ctrl = reg_wdata;
            // R9 fault clear sequence
            if (s_reg.mode_fault_flag_seen)
            begin
                s_next.csr.mode_fault_flag = 1'b0;
                s_next.mode_fault_flag_seen = 1'b0;
            end
        end
        if (data_rd)
        begin
            if (s_reg.stat_seen)
            begin
                // R2 done clear on read
                s_next.csr.transfer_done_flag = 1'b0;
                // R21 collision clear
                s_next.csr.write_collision_flag = 1'b0;
            end
            s_next.stat_seen = 1'b0;
        end
        if (data_wr && !wr_blocked)
        begin
            // R2 done clear on write
            s_next.csr.transfer_done_flag = 1'b0;
            s_next.stat_seen = 1'b0;
            if (s_reg.busy)
            begin
                // R5 collision, byte dropped
                s_next.csr.write_collision_flag = 1'b1;
            end
            else
            begin
                // R16 direct load
                s_next.shifter = reg_wdata;
                // R13 master start
                if (s_reg.ctrl.peripheral_enable && s_reg.ctrl.master_select)
                begin
                    s_next.busy = 1'b1;
                    s_next.edge_cnt = 4'h0;
                    s_next.div_cnt = half;
                    s_next.sck_lvl = s_reg.ctrl.clk_idle_high;
                end
            end
        end

        // ***************************************************
        // shift engine
        // ***************************************************
        s_next.sck_prev = pin_sync.sck;
        if (s_reg.ctrl.master_select)
        begin
            if (s_reg.busy)
            begin
                if (s_reg.div_cnt == 7'h01)
                begin
                    edge_go = 1'b1;
                    s_next.div_cnt = half;
                    s_next.sck_lvl = !s_reg.sck_lvl;
                end
                else
                begin
                    s_next.div_cnt = s_reg.div_cnt - 7'h01;
                end
            end
            else if (!(data_wr && !wr_blocked))
            begin
                s_next.sck_lvl = s_reg.ctrl.clk_idle_high;
            end
        end
        else if (sel_slave)
        begin
            edge_go = (pin_sync.sck != s_reg.sck_prev);
        end
        else
        begin
            // deselect aborts a partial slave byte
            s_next.edge_cnt = 4'h0;
            s_next.busy = 1'b0;
        end

        if (edge_go)
        begin
            smp = (s_reg.edge_cnt[0] == s_reg.ctrl.clk_phase_late);
            shf = !smp && !(s_reg.ctrl.clk_phase_late && s_reg.edge_cnt == 4'h0);
            if (s_reg.edge_cnt == ssd_pkg::LAST_EDGE)
            begin
                new_byte = {s_reg.shifter[6:0],
                            s_reg.ctrl.clk_phase_late ? in_bit : s_reg.rx_bit};
                byte_done = 1'b1;
                s_next.shifter = new_byte;
                s_next.edge_cnt = 4'h0;
                s_next.busy = 1'b0;
            end
            else
            begin
                if (smp)
                begin
                    s_next.rx_bit = in_bit;
                end
                if (shf)
                begin
                    s_next.shifter = {s_reg.shifter[6:0], s_reg.rx_bit};
                end
                s_next.edge_cnt = s_reg.edge_cnt + 4'h1;
                s_next.busy = 1'b1;
            end
        end

        // ***************************************************
        // hardware flag sets win over clears
        // ***************************************************
        if (byte_done)
        begin
            if (s_next.csr.transfer_done_flag)
            begin
                // R6 overrun, buffer keeps the unread byte
                s_next.csr.overrun_flag = 1'b1;
            end
            else
            begin
                // R14 buffer copy
                s_next.rx_buf = new_byte;
                // R1 done set
                s_next.csr.transfer_done_flag = 1'b1;
            end
        end
        // R8 mode fault
        if (s_reg.ctrl.peripheral_enable && s_reg.ctrl.master_select && !ss_int)
        begin
            s_next.csr.mode_fault_flag = 1'b1;
            // R19 drop to released slave
            s_next.ctrl.peripheral_enable = 1'b0;
            s_next.ctrl.master_select = 1'b0;
            s_next.busy = 1'b0;
            s_next.edge_cnt = 4'h0;
            s_next.sck_lvl = s_reg.ctrl.clk_idle_high;
        end

        // ***************************************************
        // registered pin and interrupt outputs
        // ***************************************************
        s_next.pins.sck_o = s_next.sck_lvl;
        s_next.pins.sck_oe = s_next.ctrl.peripheral_enable &&
                             s_next.ctrl.master_select;
        s_next.pins.mosi_o = s_next.shifter[7];
        s_next.pins.miso_o = s_next.shifter[7];
        // R10 output release
        s_next.pins.mosi_oe = s_next.ctrl.peripheral_enable &&
                              s_next.ctrl.master_select &&
                              !s_next.csr.output_disable;
        s_next.pins.miso_oe = s_next.ctrl.peripheral_enable &&
                              !s_next.ctrl.master_select &&
                              !s_next.csr.output_disable && !ss_int;
        // R11 pin left to general io
        s_next.pins.ss_gpio_free = s_next.csr.select_source_software ||
                                   !s_next.ctrl.peripheral_enable;
        // R3 single interrupt
        // R20 enable gate
        s_next.irq = s_next.ctrl.irq_enable &&
                     (s_next.csr.transfer_done_flag || s_next.csr.overrun_flag ||
                      s_next.csr.mode_fault_flag);
    end

    // ***************************************************
    // state register
    // ***************************************************
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            // R18 status clears on reset
            s_reg <= ST_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rd_data;
    assign pin_out = s_reg.pins;
    assign irq_out = s_reg.irq;

endmodule

// >>> dv/ssd_chk.sv
// Purpose: port-level checks of the serial status/data block
// Assumes: one clock domain, registers mirrored from bus writes
// Notes:   mirrors never see hardware clears, so checks allow them
`timescale 1ns/100ps
module ssd_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and interrupt
    input wire ssd_pkg::ssd_pins_in_t pin_in,
    input wire ssd_pkg::ssd_pins_out_t pin_out,
    input wire logic irq_out
);
    logic [7:0] ctl_reg;
    logic [2:0] low_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_reg <= 8'h00;
            low_reg <= 3'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == ssd_pkg::ADDR_CTRL)
                ctl_reg <= reg_wdata;
            if (reg_wr && reg_addr == ssd_pkg::ADDR_STAT)
                low_reg <= reg_wdata[2:0];
        end
    end
    sequence s_stat_rd;
        reg_rd && reg_addr == ssd_pkg::ADDR_STAT ##1 1'b1;
    endsequence
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    AST_RSVD: assert property (s_stat_rd |-> !reg_rdata[3])
        else $error("reserved status bit set");
    AST_OVR_CLR: assert property (s_stat_rd ##1 (reg_rd && reg_addr == ssd_pkg::ADDR_STAT)
        |=> !reg_rdata[5])
        else $error("overrun kept after status read");
    AST_IRQ_ON: assert property ((ctl_reg[7] && reg_rd && reg_addr == ssd_pkg::ADDR_STAT)
        ##1 (reg_rdata[7] || reg_rdata[4]) |-> irq_out)
        else $error("flag set but no interrupt");
    AST_IRQ_OFF: assert property (reg_wr && reg_addr == ssd_pkg::ADDR_CTRL && !reg_wdata[7]
        |=> ##1 !irq_out)
        else $error("interrupt while disabled");
    AST_SOD: assert property (low_reg[2] && $past(low_reg[2])
        |-> !pin_out.mosi_oe && !pin_out.miso_oe)
        else $error("data out driven while disabled");
    AST_SSM: assert property (low_reg[1] && $past(low_reg[1]) |-> pin_out.ss_gpio_free)
        else $error("select pin kept under software select");
    AST_FAULT: assert property ((ctl_reg[6] && ctl_reg[4] && !low_reg[1] && !pin_in.ss_n)[*3]
        |-> ##[1:6] !pin_out.sck_oe && !pin_out.mosi_oe)
        else $error("pins kept after select low");
    AST_SSI: assert property (ctl_reg[6] && ctl_reg[4] && low_reg[1] && !low_reg[0]
        |-> ##[1:6] !pin_out.sck_oe)
        else $error("master kept with internal select low");
endmodule
bind ssd_top ssd_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .irq_out(irq_out));

// >>> dv/ssd_slv.sv
// Purpose: external slave on the far side of the serial link
// Assumes: idle-low clock, capture on rising, shift on falling
// Notes:   reloads its reply byte while the clock is low and no bits of a byte are counted
`timescale 1ns/100ps
module ssd_slv (
    // clock
    input wire logic clk_sys,
    // link
    input wire logic sck,
    input wire logic mosi,
    input wire logic act,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic sck_d = 1'b0;
    logic [7:0] sr = 8'h00;
    logic [2:0] cnt = 3'h0;
    initial rx = 8'h00;
    // inverse while the DUT is not driving the clock (act low) so a stale bit never passes for data
    assign miso = act ? sr[7] : ~sr[7];
    always @(posedge clk_sys)
    begin
        sck_d <= sck;
        if (sck && !sck_d)
            rx <= {rx[6:0], mosi};
        else if (!sck && sck_d)
        begin
            sr <= {sr[6:0], 1'b0};
            cnt <= cnt + 3'h1;
        end
        else if (!sck && cnt == 3'h0)
            sr <= tx;
    end
endmodule

// >>> dv/tb.sv
// Purpose: self-checking bench of the serial status/data block
// Assumes: 10 MHz clock, slave model on the link
// Notes:   slave mode traffic is bit-banged at 800 ns
`timescale 1ns/100ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    ssd_pkg::ssd_pins_in_t pin_in;
    ssd_pkg::ssd_pins_out_t pin_out;
    logic irq_out;
    logic miso_m;
    logic [7:0] rx_m;
    logic [7:0] tx_m = 8'h00;
    logic ext_sck = 1'b0;
    logic ext_mosi = 1'b0;
    logic ss_pin_n = 1'b1;
    int fails = 0;
    int comparisons = 0;
    logic [15:0] lfsr = 16'h59a5;
    logic [7:0] got;
    always #50 clk_sys = ~clk_sys;
    // wire levels from every driver's enable
    assign pin_in = {pin_out.sck_oe ? pin_out.sck_o : ext_sck,
        pin_out.mosi_oe ? pin_out.mosi_o : ext_mosi,
        pin_out.miso_oe ? pin_out.miso_o : miso_m, ss_pin_n};
    ssd_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .irq_out(irq_out));
    ssd_slv u_slv (.clk_sys(clk_sys), .sck(pin_in.sck), .mosi(pin_in.mosi),
        .act(pin_out.sck_oe), .tx(tx_m), .miso(miso_m), .rx(rx_m));
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic wrap_up();
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask
    task automatic irq_is(input logic v, input int cyc);
        int n;
        n = 0;
        while (irq_out !== v && n < cyc)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, irq_out}, {7'h00, v});
    endtask
    task automatic xfer(input logic [7:0] b, input logic [7:0] t);
        tx_m = t;
        wr(ssd_pkg::ADDR_DATA, b);
        irq_is(1'b1, 400);
        chk(rx_m, b);
        rd(ssd_pkg::ADDR_STAT, 8'h83);
        rd(ssd_pkg::ADDR_DATA, t);
        repeat (2) @(negedge clk_sys);
        chk({7'h00, irq_out}, 8'h00);
    endtask
    // external master on the link, edges just after the bench clock
    // slave-out is taken on each rising link edge, settled a cycle before
    task automatic send(input logic [7:0] b, output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            ext_mosi <= b[i];
            repeat (4) @(posedge clk_sys);
            q = {q[6:0], pin_out.miso_o};
            ext_sck <= 1'b1;
            repeat (4) @(posedge clk_sys);
            ext_sck <= 1'b0;
        end
        ext_mosi <= ~b[0];
        repeat (20) @(posedge clk_sys);
    endtask
    initial
    begin
        #1000000;
        fails++;
        wrap_up();
    end
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(ssd_pkg::ADDR_STAT, 8'h00);
        rd(8'h40, ssd_pkg::RD_UNMAPPED);
        wr(ssd_pkg::ADDR_STAT, 8'hf7);
        rd(ssd_pkg::ADDR_STAT, 8'h07);
        @(posedge clk_sys);
        ss_pin_n <= 1'b0;
        wr(ssd_pkg::ADDR_STAT, 8'h03);
        wr(ssd_pkg::ADDR_CTRL, 8'hd0);
        xfer(8'hff, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            lfsr = lfsr_next(lfsr);
            xfer(lfsr[15:8], lfsr[7:0]);
        end
        wr(ssd_pkg::ADDR_DATA, 8'ha5);
        repeat (8) @(posedge clk_sys);
        wr(ssd_pkg::ADDR_DATA, 8'h3c);
        irq_is(1'b1, 400);
        wr(ssd_pkg::ADDR_DATA, 8'h55);
        repeat (80) @(posedge clk_sys);
        chk(rx_m, 8'ha5);
        rd(ssd_pkg::ADDR_STAT, 8'hc3);
        rd(ssd_pkg::ADDR_DATA, tx_m);
        rd(ssd_pkg::ADDR_STAT, 8'h03);
        wr(ssd_pkg::ADDR_CTRL, 8'h00);
        wr(ssd_pkg::ADDR_STAT, 8'h02);
        wr(ssd_pkg::ADDR_CTRL, 8'hc0);
        repeat (2) @(negedge clk_sys);
        chk({7'h00, pin_out.miso_oe}, 8'h01);
        wr(ssd_pkg::ADDR_STAT, 8'h06);
        repeat (2) @(negedge clk_sys);
        chk({7'h00, pin_out.miso_oe}, 8'h00);
        wr(ssd_pkg::ADDR_STAT, 8'h02);
        lfsr = lfsr_next(lfsr);
        wr(ssd_pkg::ADDR_DATA, lfsr[7:0]);
        send(8'h96, got);
        chk(got, lfsr[7:0]);
        send(8'h69, got);
        rd(ssd_pkg::ADDR_STAT, 8'ha2);
        rd(ssd_pkg::ADDR_STAT, 8'h82);
        rd(ssd_pkg::ADDR_DATA, 8'h96);
        wr(ssd_pkg::ADDR_CTRL, 8'h50);
        repeat (8) @(negedge clk_sys);
        chk({7'h00, irq_out}, 8'h00);
        rd(ssd_pkg::ADDR_STAT, 8'h12);
        rd(ssd_pkg::ADDR_CTRL, 8'h00);
        wr(ssd_pkg::ADDR_CTRL, 8'h00);
        rd(ssd_pkg::ADDR_STAT, 8'h02);
        @(posedge clk_sys);
        ss_pin_n <= 1'b1;
        wr(ssd_pkg::ADDR_STAT, 8'h00);
        wr(ssd_pkg::ADDR_CTRL, 8'hd0);
        ss_pin_n <= 1'b0;
        irq_is(1'b1, 12);
        rd(ssd_pkg::ADDR_STAT, 8'h10);
        rd(ssd_pkg::ADDR_CTRL, 8'h80);
        wr(ssd_pkg::ADDR_CTRL, 8'h00);
        rd(ssd_pkg::ADDR_STAT, 8'h00);
        wrap_up();
    end
endmodule
